/* hdl/lmcr_map.vh */
// Purpose: Constants for the mission control register bank
// Assumes: 8-bit registers, byte addresses on the register port
// Notes:   Times in ns, cycle counts derived at 100 MHz
`ifndef LMCR_MAP_VH
`define LMCR_MAP_VH

// ====
// Register addresses
`define LMCR_ADDR_W        10
`define LMCR_TOD_FIRST     10'h000
`define LMCR_TOD_LAST      10'h006
`define LMCR_ALM_SEC       10'h007
`define LMCR_ALM_MIN       10'h008
`define LMCR_ALM_HOUR      10'h009
`define LMCR_ALM_DAY       10'h00A
`define LMCR_INTERVAL      10'h00D
`define LMCR_CONTROL       10'h00E
`define LMCR_DELAY_LO      10'h012
`define LMCR_DELAY_HI      10'h013
`define LMCR_STATUS        10'h014

// ====
// Control fields
`define LMCR_CTL_OSC_STOP  7
`define LMCR_CTL_CLR_ARM   6
`define LMCR_CTL_PIN_START 4
`define LMCR_CTL_WRAP      3
`define LMCR_CTL_TL_IE     2
`define LMCR_CTL_TH_IE     1
`define LMCR_CTL_ALM_IE    0
`define LMCR_CTL_MASK      8'hDF
`define LMCR_CTL_RESET     8'h00

// ====
// Status fields
`define LMCR_ST_DONE       7
`define LMCR_ST_WIPED      6
`define LMCR_ST_ACTIVE     5
`define LMCR_ST_SAMPLING   4
`define LMCR_ST_BATLOW     3
`define LMCR_ST_TLOW       2
`define LMCR_ST_THIGH      1
`define LMCR_ST_ALARM      0

// ====
// Alarm mask bit and commands
`define LMCR_ALM_MASK_BIT  7
`define LMCR_CMD_CLEAR     8'hC1
`define LMCR_CMD_READ_DATA 8'hD2

// ====
// Timing
`define LMCR_PIN_HOLD_NS   500000000
`define LMCR_SIP_MAX_NS    750000000
`define LMCR_SIP_GAP_NS    250000000
`define LMCR_PIN_HOLD_CYC  (`LMCR_PIN_HOLD_NS / 10)
`define LMCR_SIP_MAX_CYC   (`LMCR_SIP_MAX_NS / 10)
`define LMCR_SIP_GAP_CYC   ((`LMCR_SIP_GAP_NS + 9) / 10)
`define LMCR_LOG_DEPTH     2048

`endif

/* hdl/lmcr_mission_regs.v */
// Purpose: Mission control and status registers of the data logger
// Assumes: Command decoder and RTC on mclk_in; pins asynchronous
// Notes:   Converters and memories live outside this block
`timescale 1ns/100ps
`default_nettype none
`include "lmcr_map.vh"

// Operation
// - Alarm masks select fields that are ignored
// - Mask is bit 7 of each alarm register
// - Oscillator stops only on battery, idle, set
// - Armed Clear Memory wipes data, disarms
// - Other command after arm only disarms
// - Pin start needs interval and 0.5 s low
// - Nonzero interval write starts when pin start off
// - First sample waits for start delay
// - Wrap mode restarts datalog at entry zero
// - Full without wrap stops writes, keeps sampling
// - Enabled flags drive the active-low interrupt
// - Measure done clears on read, sets when converted
// - Memory wiped set by clear, cleared on start
// - Logging active set by write or pin start
// - Clear or timekeeping/control write stops mission
// - Host writing zero stops logging, one ignored
// - Sampling active at most 750 ms, 250 ms gap
// - Battery low follows exhausted battery input
// - Temperature flags sticky until written zero
// - Time alarm flag sticky until written zero
// - Interval in minutes, writable only when wiped
// - Start delay counts down on minute rollovers
module lmcr_mission_regs #(
    parameter PIN_HOLD_CYC = `LMCR_PIN_HOLD_CYC,
    parameter SIP_MAX_CYC  = `LMCR_SIP_MAX_CYC,
    parameter SIP_GAP_CYC  = `LMCR_SIP_GAP_CYC,
    parameter LOG_DEPTH    = `LMCR_LOG_DEPTH,
    parameter LOG_AW       = 11
) (
    input  wire                    mclk_in,
    input  wire                    resetn_in,
    input  wire                    reg_wr_in,
    input  wire [`LMCR_ADDR_W-1:0] reg_addr_in,
    input  wire [7:0]              reg_wdata_in,
    output wire [7:0]              reg_rdata_out,
    input  wire                    cmd_valid_in,
    input  wire [7:0]              cmd_code_in,
    input  wire                    sec_tick_in,
    input  wire [7:0]              tod_sec_in,
    input  wire [7:0]              tod_min_in,
    input  wire [7:0]              tod_hour_in,
    input  wire [7:0]              tod_day_in,
    input  wire                    conv_done_in,
    input  wire                    temp_low_hit_in,
    input  wire                    temp_high_hit_in,
    input  wire                    vcc_present_in,
    input  wire                    vbat_low_in,
    input  wire                    start_status_pin_in,
    output wire                    irq_n_out,
    output wire                    osc_run_out,
    output wire                    logging_active_out,
    output wire                    sampling_active_out,
    output wire                    sample_start_out,
    output wire                    clear_mem_out,
    output wire                    log_wr_out,
    output wire [LOG_AW-1:0]       log_addr_out
);

    // ====
    // Helpers
    function field_ok;
        input [7:0] alarm;
        input [7:0] now;
        begin
            field_ok = alarm[`LMCR_ALM_MASK_BIT] |
                       (alarm[6:0] == now[6:0]);
        end
    endfunction

    function is_addr;
        input [`LMCR_ADDR_W-1:0] a;
        input [`LMCR_ADDR_W-1:0] b;
        begin
            is_addr = reg_wr_in & (a == b);
        end
    endfunction

    // ====
    // State
    reg [7:0]        ctl_reg;
    reg [7:0]        alm_sec_reg, alm_min_reg, alm_hour_reg, alm_day_reg;
    reg [7:0]        interval_reg;
    reg [15:0]       delay_reg;
    reg              done_reg, wiped_reg, active_reg, sip_reg;
    reg              batlow_reg, tlow_reg, thigh_reg, alarm_reg;
    reg              bat_s1_reg, bat_s2_reg, pin_s1_reg, pin_s2_reg;
    reg [31:0]       pin_cnt_reg;
    reg              pin_fired_reg;
    reg              first_wait_reg;
    reg [7:0]        min_cnt_reg;
    reg [31:0]       sip_cnt_reg, gap_cnt_reg;
    reg              pend_reg;
    reg              irq_n_reg, osc_reg, start_reg, clear_reg, log_wr_reg;
    reg [LOG_AW-1:0] log_addr_reg;
    reg              full_reg;
    reg [7:0]        rdata_reg;

    // ====
    // Decode
    wire cmd_clear  = cmd_valid_in & (cmd_code_in == `LMCR_CMD_CLEAR);
    wire cmd_read   = cmd_valid_in & (cmd_code_in == `LMCR_CMD_READ_DATA);
    wire do_wipe    = cmd_clear & ctl_reg[`LMCR_CTL_CLR_ARM];
    wire wr_status  = is_addr(reg_addr_in, `LMCR_STATUS);
    wire wr_ctl     = is_addr(reg_addr_in, `LMCR_CONTROL);
    wire wr_int     = is_addr(reg_addr_in, `LMCR_INTERVAL) & wiped_reg;
    wire wr_tod     = reg_wr_in & (reg_addr_in <= `LMCR_ALM_DAY);
    wire pin_start  = ctl_reg[`LMCR_CTL_PIN_START];
    wire rollover   = sec_tick_in & (tod_sec_in == 8'h00);
    wire tod_match  = sec_tick_in &
                      field_ok(alm_sec_reg, tod_sec_in) &
                      field_ok(alm_min_reg, tod_min_in) &
                      field_ok(alm_hour_reg, tod_hour_in) &
                      field_ok(alm_day_reg, tod_day_in);
    wire start_wr   = wr_int & ~pin_start &
                      (reg_wdata_in != 8'h00);
    wire start_pin  = pin_start & (interval_reg != 8'h00) & ~active_reg &
                      ~pin_fired_reg &
                      (pin_cnt_reg >= PIN_HOLD_CYC - 1);
    wire stop_req   = do_wipe | wr_tod | wr_ctl |
                      (wr_status & ~reg_wdata_in[`LMCR_ST_ACTIVE]);
    wire go         = (start_wr | start_pin) & ~active_reg;
    wire sample_due = active_reg & rollover & ~first_wait_reg &
                      (min_cnt_reg == 8'h01);
    wire first_due  = active_reg & rollover & first_wait_reg &
                      (delay_reg == 16'h0000);
    wire req        = (sample_due | first_due | cmd_read | pend_reg);
    wire can_start  = ~sip_reg & (gap_cnt_reg == 32'd0);
    wire fire       = req & can_start;

    // ====
    // Synchronisers for pins
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            bat_s1_reg <= 1'b0;
            bat_s2_reg <= 1'b0;
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            bat_s1_reg <= vbat_low_in;
            bat_s2_reg <= bat_s1_reg;
            pin_s1_reg <= start_status_pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ====
    // Configuration registers
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctl_reg      <= `LMCR_CTL_RESET;
            alm_sec_reg  <= 8'h00;
            alm_min_reg  <= 8'h00;
            alm_hour_reg <= 8'h00;
            alm_day_reg  <= 8'h00;
            interval_reg <= 8'h00;
            delay_reg    <= 16'h0000;
        end else begin
            if (wr_ctl)
                ctl_reg <= reg_wdata_in & `LMCR_CTL_MASK;
            else if (cmd_valid_in)
                ctl_reg[`LMCR_CTL_CLR_ARM] <= 1'b0;
            if (is_addr(reg_addr_in, `LMCR_ALM_SEC))
                alm_sec_reg <= reg_wdata_in;
            if (is_addr(reg_addr_in, `LMCR_ALM_MIN))
                alm_min_reg <= reg_wdata_in;
            if (is_addr(reg_addr_in, `LMCR_ALM_HOUR))
                alm_hour_reg <= reg_wdata_in;
            if (is_addr(reg_addr_in, `LMCR_ALM_DAY))
                alm_day_reg <= reg_wdata_in;
            if (do_wipe)
                interval_reg <= 8'h00;
            else if (wr_int)
                interval_reg <= reg_wdata_in;
            if (do_wipe)
                delay_reg <= 16'h0000;
            else if (is_addr(reg_addr_in, `LMCR_DELAY_LO))
                delay_reg[7:0] <= reg_wdata_in;
            else if (is_addr(reg_addr_in, `LMCR_DELAY_HI))
                delay_reg[15:8] <= reg_wdata_in;
            else if (active_reg & first_wait_reg & rollover &
                     (delay_reg != 16'h0000))
                delay_reg <= delay_reg - 16'h0001;
        end
    end

    // ====
    // Mission sequencing
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            active_reg     <= 1'b0;
            wiped_reg      <= 1'b1;
            first_wait_reg <= 1'b0;
            min_cnt_reg    <= 8'h00;
            pin_cnt_reg    <= 32'd0;
            pin_fired_reg  <= 1'b0;
            log_addr_reg   <= {LOG_AW{1'b0}};
            full_reg       <= 1'b0;
            log_wr_reg     <= 1'b0;
            clear_reg      <= 1'b0;
        end else begin
            clear_reg  <= do_wipe;
            log_wr_reg <= 1'b0;
            if (pin_s2_reg) begin
                pin_cnt_reg   <= 32'd0;
                pin_fired_reg <= 1'b0;
            end else if (start_pin) begin
                pin_fired_reg <= 1'b1;
            end else if (pin_cnt_reg < PIN_HOLD_CYC) begin
                pin_cnt_reg <= pin_cnt_reg + 32'd1;
            end
            if (stop_req) begin
                active_reg <= 1'b0;
            end else if (go) begin
                active_reg     <= 1'b1;
                first_wait_reg <= 1'b1;
            end
            if (do_wipe)
                wiped_reg <= 1'b1;
            else if (go & ~stop_req)
                wiped_reg <= 1'b0;
            if (first_due) begin
                first_wait_reg <= 1'b0;
                min_cnt_reg    <= interval_reg;
            end else if (sample_due) begin
                min_cnt_reg <= interval_reg;
            end else if (active_reg & rollover & ~first_wait_reg &
                         (min_cnt_reg != 8'h00)) begin
                min_cnt_reg <= min_cnt_reg - 8'h01;
            end
            if (do_wipe) begin
                log_addr_reg <= {LOG_AW{1'b0}};
                full_reg     <= 1'b0;
            end else if (conv_done_in & active_reg & sip_reg) begin
                if (~full_reg | ctl_reg[`LMCR_CTL_WRAP]) begin
                    log_wr_reg   <= 1'b1;
                    log_addr_reg <= log_addr_reg;
                end
            end else if (log_wr_reg) begin
                if (log_addr_reg == LOG_DEPTH - 1) begin
                    log_addr_reg <= {LOG_AW{1'b0}};
                    full_reg     <= 1'b1;
                end else begin
                    log_addr_reg <= log_addr_reg + {{(LOG_AW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // ====
    // Conversion timing and status flags
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            sip_reg     <= 1'b0;
            sip_cnt_reg <= 32'd0;
            gap_cnt_reg <= 32'd0;
            pend_reg    <= 1'b0;
            start_reg   <= 1'b0;
            done_reg    <= 1'b0;
            tlow_reg    <= 1'b0;
            thigh_reg   <= 1'b0;
            alarm_reg   <= 1'b0;
            batlow_reg  <= 1'b0;
        end else begin
            start_reg  <= fire;
            pend_reg   <= req & ~fire;
            batlow_reg <= bat_s2_reg;
            if (fire) begin
                sip_reg     <= 1'b1;
                sip_cnt_reg <= 32'd0;
            end else if (sip_reg & (conv_done_in |
                         (sip_cnt_reg >= SIP_MAX_CYC - 1))) begin
                sip_reg     <= 1'b0;
                gap_cnt_reg <= SIP_GAP_CYC;
            end else if (sip_reg) begin
                sip_cnt_reg <= sip_cnt_reg + 32'd1;
            end else if (gap_cnt_reg != 32'd0) begin
                gap_cnt_reg <= gap_cnt_reg - 32'd1;
            end
            if (sip_reg & conv_done_in)
                done_reg <= 1'b1;
            else if (cmd_read)
                done_reg <= 1'b0;
            if (temp_low_hit_in)
                tlow_reg <= 1'b1;
            else if (wr_status & ~reg_wdata_in[`LMCR_ST_TLOW])
                tlow_reg <= 1'b0;
            if (temp_high_hit_in)
                thigh_reg <= 1'b1;
            else if (wr_status & ~reg_wdata_in[`LMCR_ST_THIGH])
                thigh_reg <= 1'b0;
            if (tod_match)
                alarm_reg <= 1'b1;
            else if (wr_status & ~reg_wdata_in[`LMCR_ST_ALARM])
                alarm_reg <= 1'b0;
        end
    end

    // ====
    // Outputs and read data
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            irq_n_reg <= 1'b1;
            osc_reg   <= 1'b1;
            rdata_reg <= 8'h00;
        end else begin
            irq_n_reg <= ~((tlow_reg  & ctl_reg[`LMCR_CTL_TL_IE]) |
                           (thigh_reg & ctl_reg[`LMCR_CTL_TH_IE]) |
                           (alarm_reg & ctl_reg[`LMCR_CTL_ALM_IE]));
            osc_reg <= vcc_present_in | active_reg |
                       ~ctl_reg[`LMCR_CTL_OSC_STOP];
            case (reg_addr_in)
                `LMCR_ALM_SEC:  rdata_reg <= alm_sec_reg;
                `LMCR_ALM_MIN:  rdata_reg <= alm_min_reg;
                `LMCR_ALM_HOUR: rdata_reg <= alm_hour_reg;
                `LMCR_ALM_DAY:  rdata_reg <= alm_day_reg;
                `LMCR_INTERVAL: rdata_reg <= interval_reg;
                `LMCR_CONTROL:  rdata_reg <= ctl_reg;
                `LMCR_DELAY_LO: rdata_reg <= delay_reg[7:0];
                `LMCR_DELAY_HI: rdata_reg <= delay_reg[15:8];
                `LMCR_STATUS:   rdata_reg <= {done_reg, wiped_reg,
                                              active_reg, sip_reg,
                                              batlow_reg, tlow_reg,
                                              thigh_reg, alarm_reg};
                default:        rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out       = rdata_reg;
    assign irq_n_out           = irq_n_reg;
    assign osc_run_out         = osc_reg;
    assign logging_active_out  = active_reg;
    assign sampling_active_out = sip_reg;
    assign sample_start_out    = start_reg;
    assign clear_mem_out       = clear_reg;
    assign log_wr_out          = log_wr_reg;
    assign log_addr_out        = log_addr_reg;

endmodule // lmcr_mission_regs
`default_nettype wire

/* tb/lmcr_host_model.sv */
// Purpose: Host model for the mission control registers
// Assumes: Drives 1 ns after the rising clock edge
// Notes:   Also plays the start/status pin, pulled up when idle
`timescale 1ns/100ps
`default_nettype none
module lmcr_host_model (
    input  wire logic       mclk_in,
    input  wire logic       busy_in,
    input  wire logic [7:0] rdata_in,
    output var  logic       wr_out,
    output var  logic [9:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       cmd_valid_out,
    output var  logic [7:0] cmd_code_out,
    output var  logic       pin_n_out
);
    initial begin
        wr_out = 1'b0;
        addr_out = 10'h3FF;
        wdata_out = 8'h00;
        cmd_valid_out = 1'b0;
        cmd_code_out = 8'h00;
        pin_n_out = 1'b1;
    end
    // ====
    // Access tasks
    task automatic go();
        @(posedge mclk_in);
        #1;
        while (busy_in) begin
            @(posedge mclk_in);
            #1;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        go();
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge mclk_in);
        #1;
        wr_out = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        go();
        addr_out = a;
        @(posedge mclk_in);
        #1;
        d = rdata_in;
    endtask
    task automatic cmd(input logic [7:0] c);
        go();
        cmd_valid_out = 1'b1;
        cmd_code_out = c;
        @(posedge mclk_in);
        #1;
        cmd_valid_out = 1'b0;
    endtask
    task automatic pin(input int n);
        go();
        pin_n_out = 1'b0;
        repeat (n) @(posedge mclk_in);
        #1;
        pin_n_out = 1'b1;
    endtask
endmodule // lmcr_host_model
`default_nettype wire

/* tb/lmcr_mission_assertions.sv */
// Purpose: Port checks on the mission control registers
// Assumes: Synchronous active-low reset, one clock
// Notes:   Counts follow the instance parameters
`timescale 1ns/100ps
`default_nettype none
`include "lmcr_map.vh"
module lmcr_mission_checker #(
    parameter SIP_MAX_CYC = 50,
    parameter SIP_GAP_CYC = 10,
    parameter LOG_DEPTH   = 16,
    parameter LOG_AW      = 4
) (
    input wire logic              mclk_in,
    input wire logic              resetn_in,
    input wire logic              reg_wr_in,
    input wire logic [9:0]        reg_addr_in,
    input wire logic [7:0]        reg_wdata_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              cmd_valid_in,
    input wire logic [7:0]        cmd_code_in,
    input wire logic              conv_done_in,
    input wire logic              vcc_present_in,
    input wire logic              osc_run_out,
    input wire logic              logging_active_out,
    input wire logic              sampling_active_out,
    input wire logic              sample_start_out,
    input wire logic              clear_mem_out,
    input wire logic              log_wr_out,
    input wire logic [LOG_AW-1:0] log_addr_out
);
    logic [31:0] sip_cnt;
    logic [31:0] gap_cnt;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // ====
    // Conversion length and gap counters
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            sip_cnt <= 32'h0;
            gap_cnt <= SIP_GAP_CYC;
        end else if (sampling_active_out) begin
            sip_cnt <= sip_cnt + 32'h1;
            gap_cnt <= 32'h0;
        end else begin
            sip_cnt <= 32'h0;
            if (gap_cnt < SIP_GAP_CYC) begin
                gap_cnt <= gap_cnt + 32'h1;
            end
        end
    end
    // ====
    // Assertions
    ctl_zero_a: assert property (
        $past(reg_addr_in) == `LMCR_CONTROL |-> !reg_rdata_out[5])
        else $error("control bit 5 set");
    osc_run_a: assert property (
        $past(vcc_present_in | logging_active_out) |-> osc_run_out)
        else $error("oscillator stopped");
    clear_cmd_a: assert property (
        clear_mem_out |->
        $past(cmd_valid_in && cmd_code_in == `LMCR_CMD_CLEAR))
        else $error("clear without command");
    clear_stop_a: assert property (
        clear_mem_out |-> !logging_active_out)
        else $error("clear kept mission");
    wr_stop_a: assert property (
        reg_wr_in && (reg_addr_in <= `LMCR_ALM_DAY ||
        reg_addr_in == `LMCR_CONTROL) |=> !logging_active_out)
        else $error("write kept mission");
    host_stop_a: assert property (
        reg_wr_in && reg_addr_in == `LMCR_STATUS && !reg_wdata_in[5]
        |=> !logging_active_out)
        else $error("status write kept mission");
    sip_max_a: assert property (sip_cnt <= SIP_MAX_CYC)
        else $error("conversion too long");
    sip_gap_a: assert property (
        sample_start_out |-> gap_cnt >= SIP_GAP_CYC - 1)
        else $error("conversion inside gap");
    log_wr_a: assert property (
        log_wr_out |-> $past(conv_done_in) && $past(logging_active_out))
        else $error("log write without sample");
    log_addr_a: assert property (
        log_wr_out |=>
        log_addr_out == ($past(log_addr_out) + 1) % LOG_DEPTH)
        else $error("log pointer step wrong");
endmodule // lmcr_mission_checker
bind lmcr_mission_regs lmcr_mission_checker #(
    .SIP_MAX_CYC(SIP_MAX_CYC), .SIP_GAP_CYC(SIP_GAP_CYC),
    .LOG_DEPTH(LOG_DEPTH), .LOG_AW(LOG_AW)) u_chk (.*);
`default_nettype wire

/* tb/test_lmcr_mission_regs.sv */
// Purpose: Self-checking bench for the mission control registers
// Assumes: Host model drives bus; bench plays RTC, ADC and supplies
// Notes:   Short counts through parameters
`timescale 1ns/100ps
`default_nettype none
`include "lmcr_map.vh"
module test_lmcr_mission_regs;
    logic       mclk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic       sec_tick = 1'b0, conv_done = 1'b0, vcc = 1'b1;
    logic       t_low = 1'b0, t_high = 1'b0, vbat_low = 1'b0;
    logic [7:0] tod_sec = 8'h00, tod_min = 8'h12, tod_hour = 8'h08;
    logic [7:0] tod_day = 8'h03, rd_val;
    wire        reg_wr, cmd_valid, pin_n, irq_n, osc_run, active;
    wire        sampling, samp_start, clear_mem, log_wr;
    wire  [9:0] reg_addr;
    wire  [7:0] reg_wdata, cmd_code, rdata;
    wire  [3:0] log_addr;
    int         errors = 0, checked = 0, n_samp = 0, n_log = 0;
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        if (samp_start === 1'b1) n_samp++;
        if (log_wr === 1'b1) n_log++;
    end
    lmcr_host_model u_host (.mclk_in(mclk_in), .busy_in(sampling),
        .rdata_in(rdata), .wr_out(reg_wr), .addr_out(reg_addr),
        .wdata_out(reg_wdata), .cmd_valid_out(cmd_valid),
        .cmd_code_out(cmd_code), .pin_n_out(pin_n));
    lmcr_mission_regs #(.PIN_HOLD_CYC(20), .SIP_MAX_CYC(50),
        .SIP_GAP_CYC(10), .LOG_DEPTH(16), .LOG_AW(4)) u_dut (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .sec_tick_in(sec_tick),
        .tod_sec_in(tod_sec), .tod_min_in(tod_min), .tod_hour_in(tod_hour),
        .tod_day_in(tod_day), .conv_done_in(conv_done),
        .temp_low_hit_in(t_low), .temp_high_hit_in(t_high),
        .vcc_present_in(vcc), .vbat_low_in(vbat_low),
        .start_status_pin_in(pin_n), .irq_n_out(irq_n),
        .osc_run_out(osc_run), .logging_active_out(active),
        .sampling_active_out(sampling), .sample_start_out(samp_start),
        .clear_mem_out(clear_mem), .log_wr_out(log_wr),
        .log_addr_out(log_addr));
    // ====
    // Helpers
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rc(input string nm, input logic [9:0] a, exp);
        u_host.rd(a, rd_val);
        chk(nm, rd_val, exp[7:0]);
    endtask
    task automatic tick(input logic [7:0] s);
        wt(1);
        tod_sec = s;
        sec_tick = 1'b1;
        wt(1);
        sec_tick = 1'b0;
        wt(3);
    endtask
    task automatic conv();
        wt(1);
        conv_done = 1'b1;
        wt(1);
        conv_done = 1'b0;
    endtask
    task automatic wipe();
        u_host.wr(`LMCR_CONTROL, 8'h40);
        u_host.cmd(`LMCR_CMD_CLEAR);
        chk("clear_mem", clear_mem, 1);
    endtask
    // ====
    // Scenarios
    task automatic t_ctl();
        rc("status", `LMCR_STATUS, 8'h40);
        u_host.wr(`LMCR_CONTROL, 8'hFF);
        rc("control", `LMCR_CONTROL, 8'hDF);
        vcc = 1'b0;
        u_host.wr(`LMCR_CONTROL, 8'h80);
        wt(3);
        chk("osc_run", osc_run, 0);
        vcc = 1'b1;
        wt(3);
        chk("osc_run", osc_run, 1);
    endtask
    task automatic t_flags();
        u_host.wr(`LMCR_CONTROL, 8'h04);
        t_high = 1'b1;
        wt(1);
        t_high = 1'b0;
        wt(3);
        chk("irq_n", irq_n, 1);
        t_low = 1'b1;
        wt(1);
        t_low = 1'b0;
        wt(3);
        chk("irq_n", irq_n, 0);
        u_host.wr(`LMCR_CONTROL, 8'h00);
        wt(2);
        chk("irq_n", irq_n, 1);
        rc("status", `LMCR_STATUS, 8'h46);
        u_host.wr(`LMCR_STATUS, 8'h00);
        vbat_low = 1'b1;
        wt(4);
        rc("status", `LMCR_STATUS, 8'h48);
        vbat_low = 1'b0;
    endtask
    task automatic t_alarm();
        for (int i = 7; i <= 10; i++) u_host.wr(i, 8'h80);
        u_host.wr(`LMCR_CONTROL, 8'h01);
        tick(8'h33);
        chk("irq_n", irq_n, 0);
        u_host.wr(`LMCR_ALM_SEC, 8'h05);
        u_host.wr(`LMCR_STATUS, 8'h00);
        tick(8'h04);
        rc("status", `LMCR_STATUS, 8'h40);
        tick(8'h05);
        rc("status", `LMCR_STATUS, 8'h41);
        u_host.wr(`LMCR_STATUS, 8'h00);
        wt(2);
        chk("irq_n", irq_n, 1);
        u_host.wr(`LMCR_ALM_MIN, 8'h13);
        tick(8'h05);
        rc("status", `LMCR_STATUS, 8'h40);
        tod_min = 8'h13;
        tick(8'h05);
        rc("status", `LMCR_STATUS, 8'h41);
        u_host.wr(`LMCR_STATUS, 8'h00);
    endtask
    task automatic t_clear();
        u_host.wr(`LMCR_CONTROL, 8'h40);
        u_host.cmd(`LMCR_CMD_READ_DATA);
        chk("clear_mem", clear_mem, 0);
        wt(3);
        conv();
        rc("control", `LMCR_CONTROL, 8'h00);
        rc("status", `LMCR_STATUS, 8'hC0);
        u_host.cmd(`LMCR_CMD_READ_DATA);
        rc("status", `LMCR_STATUS, 8'h40);
        wipe();
        rc("control", `LMCR_CONTROL, 8'h00);
    endtask
    task automatic t_mission();
        int n;
        u_host.wr(`LMCR_DELAY_LO, 8'h01);
        u_host.wr(`LMCR_DELAY_HI, 8'h00);
        u_host.wr(`LMCR_INTERVAL, 8'h02);
        wt(2);
        chk("active", active, 1);
        rc("status", `LMCR_STATUS, 8'h20);
        u_host.wr(`LMCR_INTERVAL, 8'h05);
        rc("interval", `LMCR_INTERVAL, 8'h02);
        n = n_samp;
        tick(8'h00);
        rc("delay", `LMCR_DELAY_LO, 8'h00);
        chk("samples", n_samp - n, 0);
        tick(8'h00);
        chk("samples", n_samp - n, 1);
        wt(3);
        conv();
        u_host.wr(`LMCR_STATUS, 8'h3F);
        wt(2);
        chk("active", active, 1);
        u_host.wr(`LMCR_STATUS, 8'h00);
        wt(2);
        chk("active", active, 0);
    endtask
    task automatic t_restart();
        wipe();
        rc("interval", `LMCR_INTERVAL, 8'h00);
        u_host.wr(`LMCR_INTERVAL, 8'h01);
        u_host.wr(10'h003, 8'h00);
        wt(2);
        chk("active", active, 0);
        wipe();
        u_host.wr(`LMCR_CONTROL, 8'h10);
        u_host.wr(`LMCR_INTERVAL, 8'h01);
        wt(2);
        chk("active", active, 0);
        u_host.pin(8);
        wt(4);
        chk("active", active, 0);
        u_host.pin(30);
        wt(4);
        chk("active", active, 1);
    endtask
    task automatic t_log(input logic wrap);
        int n;
        wipe();
        u_host.wr(`LMCR_CONTROL, {4'h0, wrap, 3'h0});
        u_host.wr(`LMCR_INTERVAL, 8'h01);
        n = n_log;
        repeat (17) begin
            tick(8'h00);
            wt(12);
            conv();
        end
        wt(2);
        chk("log_writes", n_log - n, wrap ? 17 : 16);
        chk("log_addr", log_addr, wrap ? 1 : 0);
    endtask
    // ====
    // Sequence and verdict
    task automatic final_report();
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        #1;
        resetn_in = 1'b1;
        chk("irq_n", irq_n, 1);
        t_ctl();
        t_flags();
        t_alarm();
        t_clear();
        t_mission();
        t_restart();
        t_log(1'b0);
        t_log(1'b1);
        final_report();
    end
endmodule // test_lmcr_mission_regs
`default_nettype wire
